// ### src/tx_checksum_pkg.sv
package tx_checksum_pkg;

	// ==========================================================
	// Register offsets (index on the plain register port)
	localparam logic [7:0] REG_STATUS = 8'h07;
	localparam logic [7:0] REG_CRC_CFG = 8'h12;
	localparam logic [7:0] REG_DRV_CFG = 8'h16;
	localparam logic [7:0] REG_CTRL = 8'h20;

	// ==========================================================
	// Field positions of status and control words
	localparam int STAT_TX_BIT = 4;
	localparam int STAT_RX_BIT = 3;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_LOOP_BIT = 1;

	// ==========================================================
	// Reset values
	localparam logic [31:0] CRC_CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] DRV_CFG_RESET = 32'h0000_00FF;

	// ==========================================================
	// Checksum seeds, polynomials and masks
	localparam logic [15:0] SEED_ZERO = 16'h0000;
	localparam logic [15:0] SEED_6363 = 16'h6363;
	localparam logic [15:0] SEED_A671 = 16'hA671;
	localparam logic [15:0] SEED_FFFF = 16'hFFFF;
	localparam logic [15:0] SEED_0012 = 16'h0012;
	localparam logic [15:0] SEED_E012 = 16'hE012;
	localparam logic [2:0] SEL_CUSTOM = 3'h7;
	localparam logic [15:0] CRC16_POLY_REV = 16'h8408;
	localparam logic [15:0] CRC5_POLY_REV = 16'h0012;
	localparam logic [15:0] CRC5_MASK = 16'h001F;
	localparam logic [15:0] LSBYTE_MASK = 16'h00FF;

	// ==========================================================
	// Frame buffer shape
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_WIDTH = 9;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WAIT_TX = 3'h1,
		ST_TRANSMIT = 3'h2,
		ST_WAIT_RX = 3'h3,
		ST_WAIT_DATA = 3'h4,
		ST_RECEIVING = 3'h5,
		ST_LOOPBACK = 3'h6
	} seq_state_e;

	typedef enum logic [1:0] {
		PH_DATA = 2'h0,
		PH_CRC_LO = 2'h1,
		PH_CRC_HI = 2'h2,
		PH_DONE = 2'h3
	} tx_phase_e;

	typedef struct packed {
		logic [15:0] presetValue;
		logic [8:0] rsvd;
		logic skipFirst;
		logic [2:0] presetSel;
		logic width5;
		logic invert;
		logic enable;
	} crc_cfg_s;

	typedef struct packed {
		logic [6:0] rsvd;
		logic [2:0] clkTrans;
		logic [2:0] clkMod;
		logic [2:0] clkCarrier;
		logic [7:0] modAmp;
		logic [7:0] carrierAmp;
	} drv_cfg_s;

	typedef struct packed {
		logic last;
		logic [7:0] data;
	} frame_word_s;

endpackage

// ### src/tx_checksum.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

// ==========================================================
// Frame byte buffer
module frame_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input wire logic ref_clk, // System clock
	input wire logic resetn, // Async reset, active low
	input wire logic [WIDTH-1:0] inData, // Word to store
	input wire logic inValid, // Writer offers a word
	output logic inReady, // Room for a word
	output logic [WIDTH-1:0] outData, // Oldest word
	output logic outValid, // A word is held
	input wire logic outReady // Reader takes the word
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wPtr;
		logic [AW-1:0] rPtr;
		logic [AW:0] count;
		logic inReady;
		logic outValid;
	} fifo_state_s;

	fifo_state_s q_reg;
	fifo_state_s q_next;
	logic push;
	logic pop;

	// Full and empty kept as flops so both ready and valid are clean
	always_comb begin
		q_next = q_reg;
		push = inValid && q_reg.inReady;
		pop = outReady && q_reg.outValid;
		if (push) begin
			q_next.mem[q_reg.wPtr] = inData;
			q_next.wPtr = q_reg.wPtr + AW'(1);
		end
		if (pop) begin
			q_next.rPtr = q_reg.rPtr + AW'(1);
		end
		q_next.count = q_reg.count + (AW+1)'(push) - (AW+1)'(pop);
		q_next.inReady = q_next.count != (AW+1)'(DEPTH);
		q_next.outValid = q_next.count != '0;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			q_reg <= '0;
			q_reg.inReady <= 1'b1;
		end else begin
			q_reg <= q_next;
		end
	end

	assign inReady = q_reg.inReady;
	assign outValid = q_reg.outValid;
	assign outData = q_reg.mem[q_reg.rPtr];
endmodule

// ==========================================================
// Transmit checksum, sequencer status and driver-1 settings
module tx_checksum
	import tx_checksum_pkg::*;
(
	input wire logic ref_clk, // System clock, 100 MHz
	input wire logic resetn, // Async reset, active low
	input wire logic [7:0] addr, // Register index
	input wire logic [31:0] wrData, // Write data
	input wire logic wrStrobe, // Write strobe
	input wire logic rdStrobe, // Read strobe
	output logic [31:0] rdData, // Read data, cycle after strobe
	input wire logic [7:0] frameData, // Frame byte from the source
	input wire logic frameLast, // Marks last byte of a frame
	input wire logic frameValid, // Source offers a byte
	output logic frameReady, // Buffer has room
	output logic [7:0] txData, // Byte to the encoder
	output logic txValid, // Byte offered to the encoder
	input wire logic txReady, // Encoder takes the byte
	input wire logic rxSignal, // Decoder sees incoming data (pin)
	output logic [7:0] driver1ModAmp, // Modulated amplitude
	output logic [7:0] driver1CarrierAmp, // Carrier amplitude
	output logic [2:0] driver1ClkTrans, // Clock mode in transitions
	output logic [2:0] driver1ClkMod, // Clock mode, modulated wave
	output logic [2:0] driver1ClkCarrier // Clock mode, carrier wave
);
	typedef struct packed {
		logic rxMeta;
		logic rxSync;
		seq_state_e state;
		tx_phase_e phase;
		logic firstByte;
		logic [15:0] crc;
		crc_cfg_s crcCfg;
		drv_cfg_s drvCfg;
		logic loopback;
		logic [7:0] txData;
		logic txValid;
		logic [31:0] rdData;
	} top_state_s;

	top_state_s q_reg;
	top_state_s q_next;
	frame_word_s fifoIn;
	frame_word_s fifoOut;
	logic fifoValid;
	logic pop;
	logic canLoad;
	logic startHit;
	logic isTx;
	logic isRx;
	logic [15:0] crcOut;

	// reflected polynomial
	// One byte through the checksum, LSB first; 5-bit keeps the low bits
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d,
			input logic w5);
		logic [15:0] r;
		logic fb;
		r = c;
		for (int i = 0; i < 8; i++) begin
			fb = r[0] ^ d[i];
			r = r >> 1;
			if (fb) begin
				r = r ^ (w5 ? CRC5_POLY_REV : CRC16_POLY_REV);
			end
			if (w5) begin
				r = r & CRC5_MASK;
			end
		end
		return r;
	endfunction

	// fixed seeds
	// Seed decode; reserved code 110b falls back to zero
	function automatic logic [15:0] seed_value(input crc_cfg_s cfg);
		logic [15:0] s;
		case (cfg.presetSel)
			3'h1: s = SEED_6363;
			3'h2: s = SEED_A671;
			3'h3: s = SEED_FFFF;
			3'h4: s = SEED_0012;
			3'h5: s = SEED_E012;
			SEL_CUSTOM: s = cfg.presetValue;
			default: s = SEED_ZERO;
		endcase
		if (cfg.width5) begin
			s = s & LSBYTE_MASK;
		end
		return s;
	endfunction

	assign fifoIn.data = frameData;
	assign fifoIn.last = frameLast;

	frame_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.inData(fifoIn),
		.inValid(frameValid),
		.inReady(frameReady),
		.outData(fifoOut),
		.outValid(fifoValid),
		.outReady(pop)
	);

	// ==========================================================
	// Next-state logic
	always_comb begin
		q_next = q_reg;
		pop = 1'b0;
		// Second flop is the only reader of the first
		q_next.rxMeta = rxSignal;
		q_next.rxSync = q_reg.rxMeta;
		isTx = q_reg.state == ST_TRANSMIT;
		isRx = q_reg.state == ST_RECEIVING;
		startHit = wrStrobe && addr == REG_CTRL && wrData[CTRL_START_BIT]
			&& q_reg.state == ST_IDLE;
		canLoad = !q_reg.txValid || txReady;
		crcOut = q_reg.crcCfg.invert ? ~q_reg.crc : q_reg.crc;

		// Register writes; reserved bits are forced back to zero
		if (wrStrobe) begin
			case (addr)
				REG_CRC_CFG: begin
					q_next.crcCfg = crc_cfg_s'(wrData);
					q_next.crcCfg.rsvd = '0;
				end
				REG_DRV_CFG: begin
					q_next.drvCfg = drv_cfg_s'(wrData);
					q_next.drvCfg.rsvd = '0;
				end
				REG_CTRL: q_next.loopback = wrData[CTRL_LOOP_BIT];
				default: ;
			endcase
		end

		// Read data stands one cycle only; unmapped reads give zero
		q_next.rdData = '0;
		if (rdStrobe) begin
			case (addr)
				REG_STATUS: begin
					q_next.rdData[2:0] = q_reg.state;
					q_next.rdData[STAT_RX_BIT] = isRx;
					q_next.rdData[STAT_TX_BIT] = isTx;
				end
				REG_CRC_CFG: q_next.rdData = q_reg.crcCfg;
				REG_DRV_CFG: q_next.rdData = q_reg.drvCfg;
				REG_CTRL: q_next.rdData[CTRL_LOOP_BIT] = q_reg.loopback;
				default: ;
			endcase
		end

		// Encoder handshake: an accepted byte frees the output slot
		if (q_reg.txValid && txReady) begin
			q_next.txValid = 1'b0;
		end

		// Transceive sequencer
		unique case (q_reg.state)
			ST_IDLE: begin
				if (startHit) begin
					q_next.state = ST_WAIT_TX;
					q_next.phase = PH_DATA;
					q_next.firstByte = 1'b1;
					q_next.crc = seed_value(q_reg.crcCfg);
				end
			end
			ST_WAIT_TX: begin
				if (fifoValid) begin
					q_next.state = ST_TRANSMIT;
				end
			end
			ST_TRANSMIT: begin
				unique case (q_reg.phase)
					PH_DATA: begin
						if (canLoad && fifoValid) begin
							pop = 1'b1;
							q_next.txData = fifoOut.data;
							q_next.txValid = 1'b1;
							q_next.firstByte = 1'b0;
							if (!(q_reg.crcCfg.skipFirst && q_reg.firstByte)) begin
								q_next.crc = crc_byte(q_reg.crc, fifoOut.data,
									q_reg.crcCfg.width5);
							end
							if (fifoOut.last) begin
								q_next.phase = q_reg.crcCfg.enable ? PH_CRC_LO : PH_DONE;
							end
						end
					end
					// width picks one or two bytes
					PH_CRC_LO: begin
						if (canLoad) begin
							q_next.txValid = 1'b1;
							q_next.txData = q_reg.crcCfg.width5 ? {3'h0, crcOut[4:0]}
								: crcOut[7:0];
							q_next.phase = q_reg.crcCfg.width5 ? PH_DONE : PH_CRC_HI;
						end
					end
					PH_CRC_HI: begin
						if (canLoad) begin
							q_next.txValid = 1'b1;
							q_next.txData = crcOut[15:8];
							q_next.phase = PH_DONE;
						end
					end
					PH_DONE: begin
						if (canLoad) begin
							q_next.state = q_reg.loopback ? ST_LOOPBACK : ST_WAIT_RX;
						end
					end
				endcase
			end
			ST_WAIT_RX: q_next.state = ST_WAIT_DATA;
			ST_WAIT_DATA: begin
				if (q_reg.rxSync) begin
					q_next.state = ST_RECEIVING;
				end
			end
			ST_RECEIVING: begin
				if (!q_reg.rxSync) begin
					q_next.state = ST_IDLE;
				end
			end
			ST_LOOPBACK: q_next.state = ST_IDLE;
			default: q_next.state = ST_IDLE;
		endcase
	end

	// ==========================================================
	// State register
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			q_reg <= '0;
			q_reg.crcCfg <= crc_cfg_s'(CRC_CFG_RESET);
			q_reg.drvCfg <= drv_cfg_s'(DRV_CFG_RESET);
		end else begin
			q_reg <= q_next;
		end
	end

	assign rdData = q_reg.rdData;
	assign txData = q_reg.txData;
	assign txValid = q_reg.txValid;
	assign driver1ModAmp = q_reg.drvCfg.modAmp;
	assign driver1CarrierAmp = q_reg.drvCfg.carrierAmp;
	assign driver1ClkTrans = q_reg.drvCfg.clkTrans;
	assign driver1ClkMod = q_reg.drvCfg.clkMod;
	assign driver1ClkCarrier = q_reg.drvCfg.clkCarrier;

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	logic statusRead;
	logic lastNoAppend;
	logic loLoad16;
	assign statusRead = rdStrobe && addr == REG_STATUS;
	assign lastNoAppend = pop && fifoOut.last && !q_reg.crcCfg.enable;
	assign loLoad16 = q_reg.state == ST_TRANSMIT && q_reg.phase == PH_CRC_LO && canLoad
		&& !q_reg.crcCfg.width5;

	sequence startSeq;
		startHit;
	endsequence
	sequence waitTxSeq;
		q_reg.state == ST_WAIT_TX && q_reg.firstByte;
	endsequence

	AST_RX_ACTIVE: assert property (statusRead |=> rdData[STAT_RX_BIT] == $past(isRx))
		else $error("receive activity bit wrong");
	AST_STATE_FIELD: assert property (statusRead |=> rdData[2:0] == $past(q_reg.state))
		else $error("state field wrong");
	AST_CUSTOM_SEED: assert property (startHit && q_reg.crcCfg.presetSel == SEL_CUSTOM
		&& !q_reg.crcCfg.width5 |=> q_reg.crc == $past(q_reg.crcCfg.presetValue))
		else $error("custom seed not loaded");
	AST_SEED_A671: assert property (startHit && q_reg.crcCfg.presetSel == 3'h2
		&& !q_reg.crcCfg.width5 |=> q_reg.crc == SEED_A671)
		else $error("fixed seed wrong");
	AST_SEED_5BIT: assert property (startHit && q_reg.crcCfg.width5
		|=> q_reg.crc[15:8] == 8'h00)
		else $error("5-bit seed keeps high byte");
	AST_SKIP_FIRST: assert property (pop && q_reg.firstByte && q_reg.crcCfg.skipFirst
		|=> $stable(q_reg.crc))
		else $error("first byte entered checksum");
	AST_NO_APPEND: assert property (lastNoAppend |=> q_reg.phase == PH_DONE)
		else $error("checksum appended while disabled");
	AST_INVERT_LO: assert property (loLoad16 |=> txValid
		&& txData == ($past(q_reg.crcCfg.invert) ? ~$past(q_reg.crc[7:0])
		: $past(q_reg.crc[7:0])) && q_reg.phase == PH_CRC_HI)
		else $error("low checksum byte wrong");
	AST_TX_START: assert property (startSeq |=> waitTxSeq ##1 (isTx == $past(fifoValid) && !isRx))
		else $error("start did not reach wait-transmit");
	AST_TX_ACTIVE: assert property (statusRead |=> rdData[STAT_TX_BIT] == $past(isTx))
		else $error("transmit activity bit wrong");
	AST_DRV_AMP: assert property (wrStrobe && addr == REG_DRV_CFG
		|=> driver1ModAmp == $past(wrData[15:8]) && driver1ClkMod == $past(wrData[21:19]))
		else $error("driver setting not taken");
endmodule

// ### test/card_model.sv
`timescale 1ns/1ps
// ==========================================================
// Card side: paces the encoder and answers each frame
module card_model (
	input wire logic ref_clk, // System clock
	input wire logic resetn, // Async reset, active low
	input wire logic slow, // Take only one byte in four
	input wire logic txValid, // Encoder offers a byte
	output logic txReady, // Card takes the byte
	output logic rxSignal // Card reply on the air
);
	logic [1:0] pace;
	logic [3:0] idle;
	logic [3:0] burst;
	logic heard;

	// Reply after four quiet cycles, so a slow pace never splits a frame
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pace <= 2'h0;
			idle <= 4'h0;
			burst <= 4'h0;
			heard <= 1'b0;
			txReady <= 1'b0;
			rxSignal <= 1'b0;
		end else begin
			pace <= pace + 2'h1;
			txReady <= !slow || (pace == 2'h2);
			if (txValid) begin
				idle <= 4'h0;
				heard <= 1'b1;
			end else if (heard) begin
				idle <= idle + 4'h1;
			end
			if (heard && !txValid && idle == 4'h4) begin
				rxSignal <= 1'b1;
				burst <= 4'h6;
				heard <= 1'b0;
			end else if (burst != 4'h0) begin
				burst <= burst - 4'h1;
				rxSignal <= (burst != 4'h1); // Drops on the last count
			end
		end
	end
endmodule

// ### test/tx_checksum_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Register and frame tests of the transmit checksum block
module tx_checksum_tb;
	import tx_checksum_pkg::*;
	logic ref_clk, resetn, wrStrobe, rdStrobe, frameLast, frameValid, frameReady;
	logic [7:0] addr, frameData, txData, modAmp, carAmp;
	logic [31:0] wrData, rdData, word;
	logic txValid, txReady, rxSignal, slow;
	logic [2:0] clkTrans, clkMod, clkCar;
	logic rdPend = 1'b0;
	logic [7:0] rdAddr = 8'h00;
	logic [7:0] seenStates = 8'h00;
	logic [7:0] frame [32];
	logic [7:0] got [$];
	logic [7:0] expq [$];
	logic [15:0] seeds [8] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF, 16'h0012, 16'hE012,
		16'h0000, 16'h0000};
	logic [31:0] drv [2] = '{{7'h0, 3'h5, 3'h2, 3'h6, 8'hA5, 8'h3C},
		{7'h0, 3'h3, 3'h4, 3'h1, 8'hFF, 8'h00}};
	int fails = 0;
	int cmpCount = 0;
	int cycles = 0;

	tx_checksum u_dut (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wrData(wrData),
		.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .frameData(frameData),
		.frameLast(frameLast), .frameValid(frameValid), .frameReady(frameReady),
		.txData(txData), .txValid(txValid), .txReady(txReady), .rxSignal(rxSignal),
		.driver1ModAmp(modAmp), .driver1CarrierAmp(carAmp), .driver1ClkTrans(clkTrans),
		.driver1ClkMod(clkMod), .driver1ClkCarrier(clkCar));

	card_model u_card (.ref_clk(ref_clk), .resetn(resetn), .slow(slow), .txValid(txValid),
		.txReady(txReady), .rxSignal(rxSignal));

	// ==========================================================
	// Clock and hang guard
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			tally_and_finish();
		end
	end

	// Byte capture and status word watch on every status read
	always @(posedge ref_clk) begin
		if (txValid === 1'b1 && txReady === 1'b1) got.push_back(txData);
		rdPend <= rdStrobe;
		rdAddr <= addr;
		#1;
		if (rdPend === 1'b1 && rdAddr == REG_STATUS) begin
			seenStates[rdData[2:0]] = 1'b1;
			chk({30'h0, rdData[4:3]}, {30'h0, rdData[2:0] == 3'h2, rdData[2:0] == 3'h5});
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		cmpCount = cmpCount + 1;
		if (seen !== want) begin
			fails = fails + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge ref_clk);
		wrStrobe <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge ref_clk);
		rdStrobe <= 1'b0;
		#1 d = rdData;
	endtask

	// Back-to-back status reads until the state code shows up
	// Strobe is left high so a following poll misses no state; caller lowers it
	task automatic poll(input logic [2:0] code);
		int k;
		k = 0;
		addr <= REG_STATUS;
		rdStrobe <= 1'b1;
		@(posedge ref_clk);
		#1;
		while (rdData[2:0] !== code && k < 3000) begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		chk(rdData, {27'h0, code == 3'h2, code == 3'h5, code});
	endtask

	task automatic push(input int n);
		for (int i = 0; i < n; i++) begin
			frameValid <= 1'b1;
			frameData <= frame[i];
			frameLast <= (i == n - 1);
			#1;
			while (frameReady !== 1'b1) begin
				@(posedge ref_clk);
				#1;
			end
			@(posedge ref_clk);
		end
		frameValid <= 1'b0;
		frameLast <= 1'b0;
	endtask

	// Expected bytes come from a bit-serial model, LSB of each byte first
	task automatic run_frame(input logic [31:0] cfg, input int n, input logic lb,
		input logic slw);
		logic [15:0] c;
		c = (cfg[5:3] == 3'h7) ? cfg[31:16] : seeds[cfg[5:3]];
		if (cfg[2]) c = c & 16'h00FF;
		for (int i = int'(cfg[6]); i < n; i++) begin
			for (int b = 0; b < 8; b++) begin
				if (c[0] ^ frame[i][b]) c = (c >> 1) ^ (cfg[2] ? 16'h0012 : 16'h8408);
				else c = c >> 1;
			end
		end
		if (cfg[1]) c = ~c;
		expq.delete();
		for (int i = 0; i < n; i++) expq.push_back(frame[i]);
		if (cfg[0] && cfg[2]) expq.push_back({3'h0, c[4:0]});
		else if (cfg[0]) begin
			expq.push_back(c[7:0]);
			expq.push_back(c[15:8]);
		end
		slow <= slw;
		got.delete();
		wr(REG_CRC_CFG, cfg);
		push(n);
		if (n == FIFO_DEPTH) begin
			repeat (2) @(posedge ref_clk);
			#1 chk({31'h0, frameReady}, 32'h0);
		end
		wr(REG_CTRL, {30'h0, lb, 1'b1});
		poll(lb ? 3'h6 : 3'h5);
		poll(3'h0);
		rdStrobe <= 1'b0;
		repeat (30) @(posedge ref_clk);
		chk(got.size(), expq.size());
		if (got.size() == expq.size()) foreach (expq[i]) chk({24'h0, got[i]}, {24'h0, expq[i]});
	endtask

	task automatic tally_and_finish();
		if (fails == 0 && cmpCount > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{resetn, wrStrobe, rdStrobe, frameLast, frameValid, slow} = 6'h0;
		{addr, frameData, wrData} = 48'h0;
		for (int i = 0; i < 32; i++) frame[i] = 8'h07 + i[7:0] * 8'h1D;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(REG_CRC_CFG, word);
		chk(word, 32'h0000_0000);
		rd(REG_DRV_CFG, word);
		chk(word, 32'h0000_00FF);
		chk({16'h0, modAmp, carAmp}, 32'h0000_00FF);
		rd(8'h30, word);
		chk(word, 32'h0);
		for (int j = 0; j < 2; j++) begin
			wr(REG_DRV_CFG, drv[j] | 32'hFE00_0000);
			rd(REG_DRV_CFG, word);
			chk(word, drv[j]);
			chk({7'h0, clkTrans, clkMod, clkCar, modAmp, carAmp}, drv[j]);
		end
		wr(REG_CRC_CFG, 32'hFFFF_FFFF);
		rd(REG_CRC_CFG, word);
		chk(word, 32'hFFFF_007F);
		wr(REG_STATUS, 32'hFFFF_FFFF);
		rd(REG_STATUS, word);
		chk(word, 32'h0);
		// Every seed code, then the odd modes
		for (int s = 0; s < 8; s++) run_frame({16'hBEEF, 10'h0, s[2:0], 3'h1}, 3, 1'b0, 1'b0);
		run_frame({16'h0, 10'h0, 3'h1, 3'h3}, 3, 1'b0, 1'b1);
		run_frame({16'h0, 9'h0, 1'b1, 3'h3, 3'h1}, 3, 1'b0, 1'b0);
		run_frame({16'h0, 10'h0, 3'h5, 3'h5}, 3, 1'b0, 1'b0);
		run_frame({16'h0, 9'h0, 1'b1, 3'h4, 3'h5}, 3, 1'b1, 1'b0);
		run_frame(32'h0, FIFO_DEPTH, 1'b0, 1'b1);
		chk({24'h0, seenStates}, 32'h0000_007F);
		tally_and_finish();
	end
endmodule
